// >>> include/dmic_widget_pkg.sv
// constants for the second digital microphone pin widget
package dmic_widget_pkg;
   // node address of this widget on the link
   localparam logic [7:0] OWN_NODE = 8'h0F;
   // twelve-bit verbs
   localparam logic [11:0] VERB_GET_PARAM = 12'hF00;
   localparam logic [11:0] VERB_GET_POWER = 12'hF05;
   localparam logic [11:0] VERB_SET_POWER = 12'h705;
   localparam logic [11:0] VERB_GET_CTRL = 12'hF07;
   localparam logic [11:0] VERB_SET_CTRL = 12'h707;
   localparam logic [11:0] VERB_GET_CFG0 = 12'hF1C;
   localparam logic [11:0] VERB_SET_CFG0 = 12'h71C;
   // four-bit verbs and the set group nibble
   localparam logic [3:0] VERB_GET_AMP = 4'hB;
   localparam logic [3:0] VERB_SET_AMP = 4'h3;
   localparam logic [3:0] SET_GROUP = 4'h7;
   // parameter ids
   localparam logic [7:0] PARAM_WIDGET_CAPS = 8'h09;
   localparam logic [7:0] PARAM_PORT_CAPS = 8'h0C;
   // amplifier payload bit positions
   localparam int AMP_GET_OUT_POS = 15;
   localparam int AMP_GET_LEFT_POS = 13;
   localparam int AMP_SET_IN_POS = 14;
   localparam int AMP_SET_LEFT_POS = 13;
   localparam int AMP_SET_RIGHT_POS = 12;
   // field positions
   localparam int PWR_LOST_POS = 10;
   localparam int PWR_ERR_POS = 8;
   localparam int PWR_ACT_LSB = 4;
   localparam int INPUT_ON_POS = 5;
   // capability words
   localparam logic [31:0] WIDGET_CAPS = 32'h0040_0403;
   localparam logic [31:0] PORT_CAPS = 32'h0000_0020;
   // values after reset
   localparam logic [1:0] GAIN_RST = 2'h0;
   localparam logic [1:0] PWR_SET_RST = 2'h0;
   localparam logic [1:0] PWR_ACT_RST = 2'h3;
   localparam logic [31:0] CFG_RST = 32'h40F0_00F0;
   typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} exec_state_t;
endpackage

// >>> logic/dmic_widget_regs.sv
// verb-addressed register set of the second digital microphone pin widget
// How it works
// - capability word reports widget type 4h, pin complex, in bits 23:20
// - capability word reports zero sample delay in bits 19:16
// - capability bit 10 is one: power state control supported
// - capability bit 9 is zero: analog stream
// - capability bit 7 is zero: no spontaneous replies
// - capability bit 1 one, input gain present; output gain bit zero
// - capability bit 0 one: stereo stream
// - port capability bit 5 one; output and headset driver bits zero
// - port capability reports no plug sense, load sense or trigger
// - port capability bias level field 15:8 reads zero
// - left and right two-bit gains, reset zero, side chosen by payload
// - lost flag is one after reset, cleared by power get or any set
// - power word bit 8 set when requested state cannot be entered
// - actual power state field 5:4 read only, resets to 3h
// - requested power state in bits 1:0, resets 0h, reads back
// - control word holds input enable in bit 5, others read zero
// - default configuration bits 31:30 writable, reset 1h
// - default configuration bits 29:24 writable location, reset 00h
// - default configuration bits 23:20 writable device, reset Fh
// - default configuration bits 19:16 writable connection, reset 0h
// - color 15:12 reset 0h, association 7:4 Fh, sequence 3:0 0h
// - default configuration bits 11:8 writable, reset 0h
`timescale 1ns/1ns
`default_nettype none
module dmic_widget_regs (
   // core clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic groupRst,
   // link side, on the link bit clock
   input wire logic linkClk,
   input wire logic linkRst,
   input wire logic cmdValid,
   input wire logic [7:0] cmdNid,
   input wire logic [19:0] cmdWord,
   output logic cmdBusy,
   output logic respValid,
   output logic [31:0] respData,
   // power state refusal from the function group
   input wire logic stateDeny,
   // user side settings
   output logic [1:0] gainLeft,
   output logic [1:0] gainRight,
   output logic inputPathOn,
   output logic [1:0] powerActual,
   output logic powerError
);
   // link domain
   logic [19:0] cmdHold_reg;
   logic reqToggle_reg;
   logic busy_reg;
   logic ackS1_reg, ackS2_reg, ackS3_reg;
   logic respValid_reg;
   logic [31:0] respData_reg;
   // core domain
   logic reqS1_reg, reqS2_reg, reqS3_reg;
   logic ackToggle_reg;
   dmic_widget_pkg::exec_state_t state_reg;
   logic [31:0] respWord_reg, respNext;
   logic [1:0] gainLeft_reg, gainRight_reg;
   logic [1:0] pwrSet_reg, pwrAct_reg;
   logic pwrErr_reg, lost_reg, inOn_reg;
   logic [31:0] cfg_reg;
   logic [11:0] verb12;
   logic [3:0] verb4;
   logic [15:0] pay16;
   logic [7:0] pay8;
   logic isExec, anySet, getWcap, getPincap, getPower, setPower;
   logic getAmp, setLeft, setRight, getCtrl, setCtrl, getCfg, setCfg;

   // ---------------- link domain ----------------
   // one command in flight; others are dropped while busy
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         busy_reg <= 1'b0;
         reqToggle_reg <= 1'b0;
         cmdHold_reg <= 20'h0_0000;
      end else if (!busy_reg && cmdValid && cmdNid == dmic_widget_pkg::OWN_NODE) begin
         busy_reg <= 1'b1;
         reqToggle_reg <= ~reqToggle_reg;
         cmdHold_reg <= cmdWord;
      end else if (ackS2_reg != ackS3_reg) begin
         busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         ackS1_reg <= 1'b0;
         ackS2_reg <= 1'b0;
         ackS3_reg <= 1'b0;
      end else begin
         ackS1_reg <= ackToggle_reg;
         ackS2_reg <= ackS1_reg;
         ackS3_reg <= ackS2_reg;
      end
   end

   // answer word is stable in the core domain while the ack toggle crosses
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         respValid_reg <= 1'b0;
         respData_reg <= 32'h0000_0000;
      end else begin
         respValid_reg <= ackS2_reg != ackS3_reg;
         if (ackS2_reg != ackS3_reg) begin
            respData_reg <= respWord_reg;
         end
      end
   end

   assign cmdBusy = busy_reg;
   assign respValid = respValid_reg;
   assign respData = respData_reg;

   // ---------------- core domain ----------------
   always_ff @(posedge clk) begin
      if (srst) begin
         reqS1_reg <= 1'b0;
         reqS2_reg <= 1'b0;
         reqS3_reg <= 1'b0;
      end else begin
         reqS1_reg <= reqToggle_reg;
         reqS2_reg <= reqS1_reg;
         reqS3_reg <= reqS2_reg;
      end
   end

   // held command is stable once the request toggle has crossed
   assign verb12 = cmdHold_reg[19:8];
   assign verb4 = cmdHold_reg[19:16];
   assign pay16 = cmdHold_reg[15:0];
   assign pay8 = cmdHold_reg[7:0];
   assign isExec = state_reg == dmic_widget_pkg::ST_EXEC;
   assign anySet = verb4 == dmic_widget_pkg::VERB_SET_AMP
                   || verb12[11:8] == dmic_widget_pkg::SET_GROUP;
   assign getWcap = verb12 == dmic_widget_pkg::VERB_GET_PARAM
                    && pay8 == dmic_widget_pkg::PARAM_WIDGET_CAPS;
   assign getPincap = verb12 == dmic_widget_pkg::VERB_GET_PARAM
                      && pay8 == dmic_widget_pkg::PARAM_PORT_CAPS;
   assign getPower = verb12 == dmic_widget_pkg::VERB_GET_POWER;
   assign setPower = verb12 == dmic_widget_pkg::VERB_SET_POWER;
   assign getCtrl = verb12 == dmic_widget_pkg::VERB_GET_CTRL;
   assign setCtrl = verb12 == dmic_widget_pkg::VERB_SET_CTRL;
   assign getCfg = verb12[11:2] == dmic_widget_pkg::VERB_GET_CFG0[11:2];
   assign setCfg = verb12[11:2] == dmic_widget_pkg::VERB_SET_CFG0[11:2];
   assign getAmp = verb4 == dmic_widget_pkg::VERB_GET_AMP;
   assign setLeft = verb4 == dmic_widget_pkg::VERB_SET_AMP
                    && pay16[dmic_widget_pkg::AMP_SET_IN_POS]
                    && pay16[dmic_widget_pkg::AMP_SET_LEFT_POS];
   assign setRight = verb4 == dmic_widget_pkg::VERB_SET_AMP
                     && pay16[dmic_widget_pkg::AMP_SET_IN_POS]
                     && pay16[dmic_widget_pkg::AMP_SET_RIGHT_POS];

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= dmic_widget_pkg::ST_IDLE;
      end else begin
         unique case (state_reg)
            dmic_widget_pkg::ST_IDLE: begin
               if (reqS2_reg != reqS3_reg) begin
                  state_reg <= dmic_widget_pkg::ST_EXEC;
               end
            end
            dmic_widget_pkg::ST_EXEC: begin
               state_reg <= dmic_widget_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // answer word; unknown verbs and reserved bits answer zero
   always_comb begin
      respNext = 32'h0000_0000;
      if (getWcap) begin
         respNext = dmic_widget_pkg::WIDGET_CAPS;
      end else if (getPincap) begin
         respNext = dmic_widget_pkg::PORT_CAPS;
      end else if (getAmp && !pay16[dmic_widget_pkg::AMP_GET_OUT_POS]) begin
         respNext[1:0] = pay16[dmic_widget_pkg::AMP_GET_LEFT_POS] ? gainLeft_reg
                         : gainRight_reg;
      end else if (getPower) begin
         respNext[dmic_widget_pkg::PWR_LOST_POS] = lost_reg;
         respNext[dmic_widget_pkg::PWR_ERR_POS] = pwrErr_reg;
         respNext[dmic_widget_pkg::PWR_ACT_LSB +: 2] = pwrAct_reg;
         respNext[1:0] = pwrSet_reg;
      end else if (getCtrl) begin
         respNext[dmic_widget_pkg::INPUT_ON_POS] = inOn_reg;
      end else if (getCfg) begin
         respNext = cfg_reg;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         ackToggle_reg <= 1'b0;
         respWord_reg <= 32'h0000_0000;
      end else if (isExec) begin
         ackToggle_reg <= ~ackToggle_reg;
         respWord_reg <= respNext;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || groupRst) begin
         gainLeft_reg <= dmic_widget_pkg::GAIN_RST;
         gainRight_reg <= dmic_widget_pkg::GAIN_RST;
      end else if (isExec) begin
         if (setLeft) begin
            gainLeft_reg <= pay16[1:0];
         end
         if (setRight) begin
            gainRight_reg <= pay16[1:0];
         end
      end
   end

   // refusal keeps the old actual state and raises the error bit
   always_ff @(posedge clk) begin
      if (srst || groupRst) begin
         pwrSet_reg <= dmic_widget_pkg::PWR_SET_RST;
         pwrAct_reg <= dmic_widget_pkg::PWR_ACT_RST;
         pwrErr_reg <= 1'b0;
      end else if (isExec && setPower) begin
         pwrSet_reg <= pay8[1:0];
         pwrErr_reg <= stateDeny;
         if (!stateDeny) begin
            pwrAct_reg <= pay8[1:0];
         end
      end
   end

   // only reset sets the flag, so no set-versus-clear race exists
   always_ff @(posedge clk) begin
      if (srst || groupRst) begin
         lost_reg <= 1'b1;
      end else if (isExec && (anySet || getPower)) begin
         lost_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || groupRst) begin
         inOn_reg <= 1'b0;
      end else if (isExec && setCtrl) begin
         inOn_reg <= pay8[dmic_widget_pkg::INPUT_ON_POS];
      end
   end

   // default configuration survives a group reset, one byte per set verb
   for (genvar b = 0; b < 4; b++) begin : gCfgByte
      always_ff @(posedge clk) begin
         if (srst) begin
            cfg_reg[8*b +: 8] <= dmic_widget_pkg::CFG_RST[8*b +: 8];
         end else if (isExec && setCfg && verb12[1:0] == 2'(b)) begin
            cfg_reg[8*b +: 8] <= pay8;
         end
      end
   end

   assign gainLeft = gainLeft_reg;
   assign gainRight = gainRight_reg;
   assign inputPathOn = inOn_reg;
   assign powerActual = pwrAct_reg;
   assign powerError = pwrErr_reg;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_type_field: assert property (
      isExec && getWcap |=> respWord_reg[23:20] == 4'h4)
      else $error("widget type not pin complex");
   chk_delay_field: assert property (
      isExec && getWcap |=> respWord_reg[19:16] == 4'h0)
      else $error("sample delay not zero");
   chk_power_cap: assert property (
      isExec && getWcap |=> respWord_reg[10])
      else $error("power control bit clear");
   chk_analog_stream: assert property (
      isExec && getWcap |=> !respWord_reg[9])
      else $error("digital stream bit set");
   chk_no_unsolicited: assert property (
      isExec && getWcap |=> !respWord_reg[7])
      else $error("spontaneous reply bit set");
   chk_amp_present: assert property (
      isExec && getWcap |=> respWord_reg[1] && !respWord_reg[2])
      else $error("amplifier present bits wrong");
   chk_stereo_bit: assert property (
      isExec && getWcap |=> respWord_reg[0])
      else $error("stereo bit clear");
   chk_port_input: assert property (
      isExec && getPincap |=> respWord_reg[5:3] == 3'h4)
      else $error("port direction bits wrong");
   chk_port_sense: assert property (
      isExec && getPincap |=> respWord_reg[2:0] == 3'h0)
      else $error("port sense bits set");
   chk_port_bias: assert property (
      isExec && getPincap |=> respWord_reg[15:8] == 8'h00)
      else $error("bias support not zero");
   chk_left_gain: assert property (
      isExec && setLeft && !groupRst |=> gainLeft_reg == $past(pay16[1:0]))
      else $error("left gain not stored");
   chk_gain_read: assert property (
      isExec && getAmp && !pay16[15] && !pay16[13] |=>
      respWord_reg == {30'h0, $past(gainRight_reg)})
      else $error("right gain read wrong");
   chk_lost_clear: assert property (
      isExec && (anySet || getPower) && !groupRst |=> !lost_reg)
      else $error("lost flag not cleared");
   chk_lost_reset: assert property (
      $fell(srst) |-> lost_reg && pwrAct_reg == 2'h3 && pwrSet_reg == 2'h0)
      else $error("power word reset wrong");
   chk_power_error: assert property (
      isExec && setPower && !groupRst |=> pwrErr_reg == $past(stateDeny))
      else $error("power error not tracking refusal");
   chk_power_read: assert property (
      isExec && getPower |=> respWord_reg[1:0] == $past(pwrSet_reg)
      && respWord_reg[5:4] == $past(pwrAct_reg))
      else $error("power readback wrong");
   chk_ctrl_word: assert property (
      isExec && getCtrl |=> respWord_reg == {26'h0, $past(inOn_reg), 5'h00})
      else $error("control word wrong");
   chk_cfg_reset: assert property (
      $fell(srst) |-> cfg_reg == 32'h40F0_00F0)
      else $error("configuration reset wrong");
   chk_cfg_write: assert property (
      isExec && setCfg && verb12[1:0] == 2'h3 |=> cfg_reg[31:24] == $past(pay8))
      else $error("configuration top byte not stored");
   chk_reserved_zero: assert property (
      isExec && getPower |=> respWord_reg[31:11] == 21'h0
      && respWord_reg[9] == 1'b0 && respWord_reg[7:6] == 2'h0)
      else $error("reserved power bits set");
   chk_act_follow: assert property (
      isExec && setPower && !stateDeny && !groupRst |=>
      pwrAct_reg == $past(pay8[1:0]))
      else $error("actual state not following setting");
   chk_resp_pulse: assert property (@(posedge linkClk) disable iff (linkRst)
      respValid_reg |=> !respValid_reg)
      else $error("answer strobe longer than one cycle");

   cov_get_power: cover property (isExec && getPower);
   cov_set_left: cover property (isExec && setLeft);
   cov_set_cfg: cover property (isExec && setCfg);
   cov_refused: cover property (isExec && setPower && stateDeny);
endmodule
`default_nettype wire

// >>> test/link_host_model.sv
// controller-side model that places verbs on the command link
`timescale 1ns/1ns
`default_nettype none
module link_host_model (
   // link clock
   input wire logic linkClk,
   // command lines
   output logic cmdValid,
   output logic [7:0] cmdNid,
   output logic [19:0] cmdWord
);
   initial begin
      cmdValid = 1'b0;
      cmdNid = 8'hA5;
      cmdWord = 20'h5A5A5;
   end
   // one-cycle strobe; the payload picks side and setting
   task automatic issue(input logic [7:0] nid, input logic [19:0] word);
      @(negedge linkClk);
      cmdValid = 1'b1;
      cmdNid = nid;
      cmdWord = word;
      @(negedge linkClk);
      cmdValid = 1'b0;
      // released lines show the inverse, never a stale copy
      cmdNid = ~nid;
      cmdWord = ~word;
   endtask
endmodule
`default_nettype wire

// >>> test/test_digital_mic_pin_widget_regs.sv
// self-checking bench for the microphone pin widget registers
`timescale 1ns/1ns
`default_nettype none
module test_digital_mic_pin_widget_regs;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic srst = 1'b1;
   logic linkRst = 1'b1;
   logic groupRst = 1'b0;
   logic stateDeny = 1'b0;
   logic cmdValid, cmdBusy, respValid, inputPathOn, powerError;
   logic [7:0] cmdNid;
   logic [19:0] cmdWord;
   logic [31:0] respData;
   logic [1:0] gainLeft, gainRight, powerActual;
   int error_cnt = 0;
   int compares = 0;
   integer seed = 32'h12cf;
   logic [31:0] expQ[$];
   string nameQ[$];

   always #5 clk = ~clk;
   // odd start offset keeps the link clock edges off the core's falling edges
   initial begin
      #3;
      forever #16 linkClk = ~linkClk;
   end

   link_host_model i_link_host_model (.linkClk(linkClk), .cmdValid(cmdValid),
      .cmdNid(cmdNid), .cmdWord(cmdWord));
   dmic_widget_regs i_dmic_widget_regs (.clk(clk), .srst(srst), .groupRst(groupRst),
      .linkClk(linkClk), .linkRst(linkRst), .cmdValid(cmdValid), .cmdNid(cmdNid),
      .cmdWord(cmdWord), .cmdBusy(cmdBusy), .respValid(respValid), .respData(respData),
      .stateDeny(stateDeny), .gainLeft(gainLeft), .gainRight(gainRight),
      .inputPathOn(inputPathOn), .powerActual(powerActual), .powerError(powerError));

   task automatic final_report();
      $display("compares %0d, errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_answer();
      int n;
      n = 0;
      while (respValid !== 1'b1 && n < 20) begin
         @(negedge linkClk);
         n++;
      end
      if (n == 20) begin
         error_cnt++;
         $display("unexpected answer wait: expected answer, seen none");
         final_report();
      end
   endtask

   task automatic xfer(input string what, input logic [19:0] word, input logic [31:0] exp);
      expQ.push_back(exp);
      nameQ.push_back(what);
      i_link_host_model.issue(dmic_widget_pkg::OWN_NODE, word);
      check("cmdBusy", {31'h0, cmdBusy}, 32'h0000_0001);
      wait_answer();
      check("cmdBusy", {31'h0, cmdBusy}, 32'h0000_0000);
   endtask

   // oldest note is matched against each answer, mid-cycle where it is settled
   always @(negedge linkClk) begin
      if (respValid === 1'b1) begin
         if (expQ.size() == 0) begin
            error_cnt++;
            $display("unexpected answer: expected none, seen %h", respData);
         end else begin
            check(nameQ.pop_front(), respData, expQ.pop_front());
         end
      end
   end

   initial begin
      logic [7:0] b [4];
      logic [1:0] ps;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      @(negedge linkClk);
      linkRst = 1'b0;
      repeat (5) @(negedge clk);
      xfer("widget caps", 20'hF0009, 32'h0040_0403);
      xfer("port caps", 20'hF000C, 32'h0000_0020);
      xfer("power word", 20'hF0500, 32'h0000_0430);
      xfer("power word", 20'hF0500, 32'h0000_0030);
      xfer("config", 20'hF1F00, 32'h40F0_00F0);
      xfer("left gain", 20'hB2000, 32'h0000_0000);
      xfer("output gain", 20'hBA000, 32'h0000_0000);
      xfer("unknown verb", 20'hF2000, 32'h0000_0000);
      // second command lands while busy and must vanish
      expQ.push_back(32'h0040_0403);
      nameQ.push_back("caps under busy");
      i_link_host_model.issue(dmic_widget_pkg::OWN_NODE, 20'hF0009);
      i_link_host_model.issue(dmic_widget_pkg::OWN_NODE, 20'hF0500);
      wait_answer();
      i_link_host_model.issue(8'h0E, 20'hF0500);
      repeat (12) @(negedge linkClk);
      repeat (4) begin
         b[0] = 8'($random(seed));
         b[1] = 8'($random(seed));
         xfer("gain set", {12'h360, b[0]}, 32'h0000_0000);
         xfer("gain set", {12'h350, b[1]}, 32'h0000_0000);
         xfer("left gain", 20'hB2000, {30'h0, b[0][1:0]});
         xfer("right gain", 20'hB0000, {30'h0, b[1][1:0]});
         check("gainLeft", {30'h0, gainLeft}, {30'h0, b[0][1:0]});
         check("gainRight", {30'h0, gainRight}, {30'h0, b[1][1:0]});
      end
      for (int s = 0; s < 4; s++) begin
         ps = 2'(s);
         xfer("power set", {12'h705, 6'h3C, ps}, 32'h0000_0000);
         xfer("power word", 20'hF0500, {26'h0, ps, 2'h0, ps});
         check("powerActual", {30'h0, powerActual}, {30'h0, ps});
      end
      @(negedge clk);
      stateDeny = 1'b1;
      xfer("power set", 20'h70501, 32'h0000_0000);
      xfer("power word", 20'hF0500, 32'h0000_0131);
      check("powerError", {31'h0, powerError}, 32'h0000_0001);
      check("powerActual", {30'h0, powerActual}, 32'h0000_0003);
      @(negedge clk);
      stateDeny = 1'b0;
      for (int k = 0; k < 2; k++) begin
         b[0] = k == 0 ? 8'hFF : 8'hDF;
         xfer("control set", {12'h707, b[0]}, 32'h0000_0000);
         xfer("control", 20'hF0700, {26'h0, b[0][5], 5'h0});
         check("inputPathOn", {31'h0, inputPathOn}, {31'h0, b[0][5]});
      end
      for (int k = 0; k < 4; k++) begin
         b[k] = 8'($random(seed));
         xfer("config set", {12'h71C + 12'(k), b[k]}, 32'h0000_0000);
      end
      xfer("config", 20'hF1C00, {b[3], b[2], b[1], b[0]});
      xfer("config", 20'hF1E00, {b[3], b[2], b[1], b[0]});
      @(negedge clk);
      groupRst = 1'b1;
      @(negedge clk);
      groupRst = 1'b0;
      repeat (3) @(negedge clk);
      check("gainLeft", {30'h0, gainLeft}, 32'h0000_0000);
      check("powerActual", {30'h0, powerActual}, 32'h0000_0003);
      xfer("power word", 20'hF0500, 32'h0000_0430);
      xfer("config", 20'hF1D00, {b[3], b[2], b[1], b[0]});
      // let the watcher take the last answer before the verdict
      repeat (2) @(negedge linkClk);
      check("pending answers", 32'(expQ.size()), 32'h0000_0000);
      final_report();
   end
endmodule
`default_nettype wire
